// [hdl/kdcu_pkg.sv]
package kdcu_pkg;

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int         DATA_W   = 32;
  localparam int         ADDR_W   = 32;
  localparam logic [7:0] REG_SEL  = 8'h00;
  localparam logic [7:0] REG_CMD  = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;

  // Field positions in command and select words
  localparam int ACC_LSB = 8;
  localparam int CIN_BIT = 12;
  localparam int HI_LSB  = 4;
  localparam logic [1:0] SEL_ID = 2'h1;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_MODE = 8'hE4;
  localparam logic [7:0] OP_PRST = 8'hE5;
  localparam logic [7:0] OP_FCLR = 8'hE6;
  localparam logic [7:0] OP_KCLR = 8'hE7;
  localparam logic [7:0] OP_AWR  = 8'hE0;
  localparam logic [7:0] OP_ARD  = 8'hE9;
  localparam logic [7:0] OP_HWR  = 8'hE1;
  localparam logic [7:0] OP_HRD  = 8'hEF;
  localparam logic [7:0] OP_ADD  = 8'hEB;
  localparam logic [7:0] OP_SUB  = 8'hE8;
  localparam logic [7:0] OP_CNT  = 8'hEC;
  localparam logic [7:0] OP_FNIB = 8'hED;
  localparam logic [7:0] OP_SNIB = 8'hEE;

  // ----------------------------------------------------------------
  // Modes, reset values, codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {DM_INDIV, DM_GD20, DM_GD18, DM_GD16} kdcu_disp_t;
  typedef enum logic [1:0] {IM_SENSOR, IM_SCANKB, IM_ENCKB, IM_NONE} kdcu_in_t;
  localparam kdcu_disp_t RST_DISP   = DM_GD16;
  localparam kdcu_in_t   RST_IN     = IM_SCANKB;
  localparam logic [3:0] BLANK_IND  = 4'hF;
  localparam logic [5:0] BLANK_CHAR = 6'h20;
  localparam logic [3:0] OVR_STATUS = 4'hF;
  localparam logic [3:0] FIFO_FULL  = 4'h8;
  localparam int         NCHAR_MAX  = 20;
  localparam logic [4:0] NCH16      = 5'h10;
  localparam logic [4:0] NCH18      = 5'h12;
  localparam logic [4:0] NCH20      = 5'h14;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ         = 10_000_000;
  localparam int CLK_PERIOD_NS  = 100;
  localparam int SCAN_HZ        = 180;
  localparam int SCAN_DIGITS    = 16;
  localparam int SCAN_STEP_CYC  = CLK_HZ / (SCAN_HZ * SCAN_DIGITS);
  localparam int GCLK_PERIOD_NS = 100_000;
  localparam int GCLK_HALF_CYC  = GCLK_PERIOD_NS / CLK_PERIOD_NS / 2;
  localparam logic [7:0] FRAME_SHORT = 8'd111;
  localparam logic [7:0] FRAME_LONG  = 8'd139;
  localparam logic [2:0] CHAR_LEN7   = 3'd7;
  localparam logic [2:0] CHAR_LEN6   = 3'd6;
  localparam logic [2:0] DATA_CLKS   = 3'd5;
  localparam logic [7:0] BLANK18_IDX = 8'd107;

endpackage

// [hdl/kdcu_top.sv]
`timescale 1ns/10ps

// What this block does
// - Eight-deep register shows each digit at 360 Hz, sixteen-deep at 180 Hz.
// - Reset makes both display registers sixteen nibbles deep.
// - Eight-deep shows eight locations from the advancing-write offset (mod 16); the other eight stay plain storage.
// - Advancing ops step all sixteen locations; advancing write rotates whole register.
// - Gas select codes point at A/B character; blank forms force outputs to 20h.
// - Gas pointer reset goes to A0 and fills registers with blank code.
// - Gas advancing write stores, shifts display, steps pointer A0,B0,A1,B1.
// - Gas advancing read returns nibble and steps pointer, no display shift.
// - Hold write/read keep pointer; add with carry, subtract with borrow.
// - Extra 18/20 characters reached only by advancing past 15, then by hold ops.
// - Sensor select nibble bits 3..1 pick sensor group through the pointer.
// - Sensor mode samples 64 points; interrupt while any stored bit set.
// - FIFO clear empties FIFO/sensor RAM, status count and interrupt.
// - First-nibble read peeks; second-nibble read returns and pops the entry.
// - Count read gives 0..8, or 15 on overrun keeping first eight.
// - Interrupt rises on entry, dips one cycle per second-nibble read until empty.
// - Ninth entry sets overrun; interrupt stays until a clear opcode.
// - Scanned mode pairs LSD with S0; bank select open then low.
// - Gas clock about 100 us, 50 %, reset pulse every 111th or 139th.
// - Character is 7 clocks (6 for 18), data in first five, 18 blanks 107..110.
// - Gas outputs: A3 reset, A2 clock, six character bits elsewhere.
// - Mode write takes display mode from bits 3..2, input from 1..0.
// - Reset defaults to scanned keyboard and 16-character gas mode.
// - Opcodes ignored until selected by a select word with top bits 01.
// - Keyboard/display clear resets logic and fills display with blank code.
module kdcu_top (
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  input  wire logic                         hsel,
  input  wire logic [kdcu_pkg::ADDR_W-1:0]  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [kdcu_pkg::DATA_W-1:0]  hwdata,
  input  wire logic                         hready,
  output logic                              hreadyout,
  output logic                              hresp,
  output logic      [kdcu_pkg::DATA_W-1:0]  hrdata,
  input  wire logic [7:0]                   ret_in,
  input  wire logic                         key_stb_in,
  output logic      [3:0]                   disp_a_o,
  output logic      [3:0]                   disp_b_o,
  output logic      [7:0]                   scan_o,
  output logic                              bank_select_out_o,
  output logic                              bank_select_out_oe,
  output logic                              int_o
);
  import kdcu_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [4:0] wrap_add(input logic [4:0] a, input logic [4:0] b,
                                          input logic [4:0] n);
    logic [5:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, n}) begin
      s = s - {1'b0, n};
    end
    return s[4:0];
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic        wr_q;
  logic        rd_pend_q;
  logic [7:0]  addr_q;
  logic        ready_q;
  logic [31:0] rdata_q;
  logic        zero_q;
  logic        acc_ok;
  logic [31:0] rd_val;

  assign acc_ok = hsel && htrans[1] && hready;

  // Reads take one wait state so they see the effect of a write just before
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q      <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
      ready_q   <= 1'b1;
      rdata_q   <= 32'h0000_0000;
      zero_q    <= 1'b0;
    end else begin
      wr_q <= acc_ok && hwrite;
      if (acc_ok) begin
        addr_q    <= haddr[7:0];
        rd_pend_q <= !hwrite;
        ready_q   <= hwrite;
      end else if (rd_pend_q) begin
        rdata_q   <= rd_val;
        rd_pend_q <= 1'b0;
        ready_q   <= 1'b1;
      end
    end
  end

  assign hreadyout         = ready_q;
  assign hresp             = zero_q;
  assign hrdata            = rdata_q;
  assign bank_select_out_o = zero_q;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic       sel_q;
  logic       sel_go;
  logic       sel_ok;
  logic       ex;
  logic [7:0] op;
  logic [3:0] acc;
  logic       cin;
  logic [3:0] hi;
  logic [3:0] lo;

  assign sel_go = wr_q && (addr_q == REG_SEL);
  assign hi     = hwdata[HI_LSB +: 4];
  assign lo     = hwdata[3:0];
  assign sel_ok = sel_go && (hi[3:2] == SEL_ID);
  assign ex     = wr_q && (addr_q == REG_CMD) && sel_q;
  assign op     = hwdata[7:0];
  assign acc    = hwdata[ACC_LSB +: 4];
  assign cin    = hwdata[CIN_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_q <= 1'b0;
    end else if (sel_go) begin
      sel_q <= sel_ok;
    end
  end

  logic op_mode, op_prst, op_fclr, op_kclr, op_awr, op_ard, op_hwr;
  logic op_hrd, op_add, op_sub, op_cnt, op_fnib, op_snib, clr;
  assign op_mode = ex && (op == OP_MODE);
  assign op_prst = ex && (op == OP_PRST);
  assign op_fclr = ex && (op == OP_FCLR);
  assign op_kclr = ex && (op == OP_KCLR);
  assign op_awr  = ex && (op == OP_AWR);
  assign op_ard  = ex && (op == OP_ARD);
  assign op_hwr  = ex && (op == OP_HWR);
  assign op_hrd  = ex && (op == OP_HRD);
  assign op_add  = ex && (op == OP_ADD);
  assign op_sub  = ex && (op == OP_SUB);
  assign op_cnt  = ex && (op == OP_CNT);
  assign op_fnib = ex && (op == OP_FNIB);
  assign op_snib = ex && (op == OP_SNIB);
  assign clr     = op_fclr || op_kclr;

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  kdcu_disp_t dm_q;
  kdcu_in_t   im_q;
  logic       deep_a_q;
  logic       deep_b_q;
  logic       blank_a_q;
  logic       blank_b_q;
  logic       gas;
  logic       kb;
  logic [4:0] nch;

  assign gas = (dm_q != DM_INDIV);
  assign kb  = (im_q == IM_SCANKB) || (im_q == IM_ENCKB);
  assign nch = (dm_q == DM_GD20) ? NCH20 : ((dm_q == DM_GD18) ? NCH18 : NCH16);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dm_q      <= RST_DISP;
      im_q      <= RST_IN;
      deep_a_q  <= 1'b0;
      deep_b_q  <= 1'b0;
      blank_a_q <= 1'b0;
      blank_b_q <= 1'b0;
    end else begin
      if (op_mode) begin
        dm_q <= kdcu_disp_t'(acc[3:2]);
        im_q <= kdcu_in_t'(acc[1:0]);
      end
      if (op_prst && !gas) begin
        deep_b_q <= acc[3];
        deep_a_q <= acc[2];
      end
      if (sel_ok && gas) begin
        blank_a_q <= hi[1];
        blank_b_q <= hi[1];
      end else if (sel_ok && hi[0]) begin
        blank_b_q <= hi[1];
      end else if (sel_ok) begin
        blank_a_q <= hi[1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Display registers and pointer
  // ----------------------------------------------------------------
  logic [3:0] mem_a [0:NCHAR_MAX-1];
  logic [3:0] mem_b [0:NCHAR_MAX-1];
  logic       ptr_b_q;
  logic [4:0] ptr_q;
  logic [3:0] off_a_q;
  logic [3:0] off_b_q;
  logic [4:0] goff_q;
  logic       adv_b;
  logic [4:0] adv_i;
  logic [3:0] pn;

  assign pn = ptr_b_q ? mem_b[ptr_q] : mem_a[ptr_q];

  always_comb begin
    adv_b = ptr_b_q;
    adv_i = {1'b0, ptr_q[3:0] + 4'h1};
    if (gas) begin
      adv_b = !ptr_b_q;
      adv_i = ptr_b_q ? wrap_add(ptr_q, 5'h01, nch) : ptr_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int k = 0; k < NCHAR_MAX; k++) begin
        mem_a[k] <= 4'h0;
        mem_b[k] <= 4'h0;
      end
    end else if (op_prst || op_kclr) begin
      for (int k = 0; k < NCHAR_MAX; k++) begin
        mem_a[k] <= gas ? {2'h0, BLANK_CHAR[5:4]} : BLANK_IND;
        mem_b[k] <= gas ? BLANK_CHAR[3:0] : BLANK_IND;
      end
    end else if (op_awr || op_hwr) begin
      if (ptr_b_q) begin
        mem_b[ptr_q] <= acc;
      end else begin
        mem_a[ptr_q] <= acc;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr_b_q <= 1'b0;
      ptr_q   <= 5'h00;
      off_a_q <= 4'h0;
      off_b_q <= 4'h0;
      goff_q  <= 5'h00;
    end else if (op_prst || op_kclr) begin
      ptr_b_q <= 1'b0;
      ptr_q   <= 5'h00;
      off_a_q <= 4'h0;
      off_b_q <= 4'h0;
      goff_q  <= 5'h00;
    end else if (sel_ok && im_q == IM_SENSOR) begin
      ptr_q <= {1'b0, lo[3:1], 1'b0};
    end else if (sel_ok) begin
      ptr_b_q <= hi[0];
      ptr_q   <= {1'b0, lo};
    end else if (op_awr || op_ard) begin
      ptr_b_q <= adv_b;
      ptr_q   <= adv_i;
      // Gas shift happens once per whole character, on its B half
      if (op_awr && gas && ptr_b_q) begin
        goff_q <= wrap_add(goff_q, 5'h01, nch);
      end else if (op_awr && !gas && ptr_b_q) begin
        off_b_q <= off_b_q + 4'h1;
      end else if (op_awr && !gas) begin
        off_a_q <= off_a_q + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Scan strobes and sampled inputs
  // ----------------------------------------------------------------
  logic [7:0]  ret_m_q;
  logic [7:0]  ret_s_q;
  logic [2:0]  stb_q;
  logic [11:0] step_q;
  logic [2:0]  s_q;
  logic        bank_q;
  logic [7:0]  scan_q;
  logic        step_end;

  assign step_end = (step_q == 12'(SCAN_STEP_CYC - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ret_m_q <= 8'h00;
      ret_s_q <= 8'h00;
      stb_q   <= 3'h0;
    end else begin
      ret_m_q <= ret_in;
      ret_s_q <= ret_m_q;
      stb_q   <= {stb_q[1:0], key_stb_in};
    end
  end

  // Step length is fixed; eight-deep simply ignores the bank bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_q <= 12'h000;
      s_q    <= 3'h0;
      bank_q <= 1'b0;
      scan_q <= 8'h01;
    end else if (step_end) begin
      step_q <= 12'h000;
      s_q    <= s_q + 3'h1;
      scan_q <= {scan_q[6:0], scan_q[7]};
      if (s_q == 3'h7) begin
        bank_q <= !bank_q;
      end
    end else begin
      step_q <= step_q + 12'h001;
    end
  end

  assign scan_o             = scan_q;
  assign bank_select_out_oe = bank_q;

  // ----------------------------------------------------------------
  // FIFO and sensor RAM
  // ----------------------------------------------------------------
  logic [7:0] fifo [0:7];
  logic [7:0] sens_q [0:7];
  logic [2:0] wp_q;
  logic [2:0] rp_q;
  logic [3:0] cnt_q;
  logic       ovr_q;
  logic       push;
  logic       pop;
  logic       put;
  logic [3:0] fstat;
  logic       sens_any;
  logic [7:0] cur;
  logic [7:0] grp;

  assign push  = kb && stb_q[1] && !stb_q[2];
  assign pop   = op_snib && kb && (cnt_q != 4'h0);
  assign put   = push && (clr || cnt_q != FIFO_FULL || pop);
  assign fstat = ovr_q ? OVR_STATUS : cnt_q;
  assign cur   = fifo[rp_q];
  assign grp   = sens_q[ptr_q[3:1]];

  always_comb begin
    sens_any = 1'b0;
    for (int k = 0; k < 8; k++) begin
      sens_any = sens_any || (sens_q[k] != 8'h00);
    end
  end

  always_ff @(posedge hclk) begin
    if (put) begin
      fifo[clr ? 3'h0 : wp_q] <= ret_s_q;
    end
  end

  // A key arriving with a clear survives it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_q  <= 3'h0;
      rp_q  <= 3'h0;
      cnt_q <= 4'h0;
      ovr_q <= 1'b0;
    end else if (clr) begin
      wp_q  <= put ? 3'h1 : 3'h0;
      rp_q  <= 3'h0;
      cnt_q <= put ? 4'h1 : 4'h0;
      ovr_q <= 1'b0;
    end else begin
      if (put) begin
        wp_q <= wp_q + 3'h1;
      end
      if (pop) begin
        rp_q <= rp_q + 3'h1;
      end
      if (push && !put) begin
        ovr_q <= 1'b1;
      end
      cnt_q <= cnt_q + {3'h0, put} - {3'h0, pop};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int k = 0; k < 8; k++) begin
        sens_q[k] <= 8'h00;
      end
    end else begin
      if (clr) begin
        for (int k = 0; k < 8; k++) begin
          sens_q[k] <= 8'h00;
        end
      end
      if (step_end && im_q == IM_SENSOR) begin
        sens_q[s_q] <= ret_s_q;
      end
    end
  end

  // Interrupt dips for the cycle after each keyboard-mode second-nibble read, then follows the count and overrun flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_o <= 1'b0;
    end else if (clr) begin
      // A key landing with the clear still raises the interrupt
      int_o <= put;
    end else if (im_q == IM_SENSOR) begin
      int_o <= sens_any;
    end else begin
      int_o <= kb && (cnt_q != 4'h0 || ovr_q) && !op_snib;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator results
  // ----------------------------------------------------------------
  logic [4:0] res_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_q <= 5'h00;
    end else if (op_ard || op_hrd) begin
      res_q <= {cin, pn};
    end else if (op_add) begin
      res_q <= {1'b0, acc} + {1'b0, pn} + {4'h0, cin};
    end else if (op_sub) begin
      res_q <= {1'b0, acc} + {1'b0, ~pn} + {4'h0, !cin};
    end else if (op_cnt) begin
      res_q <= {cin, fstat};
    end else if (op_fnib) begin
      res_q <= {cin, kb ? cur[7:4] : grp[7:4]};
    end else if (op_snib) begin
      res_q <= {cin, kb ? cur[3:0] : grp[3:0]};
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (addr_q)
      REG_SEL:  rd_val = {31'h0, sel_q};
      REG_CMD:  rd_val = {27'h0, res_q};
      REG_STAT: rd_val = {15'h0, int_o, fstat, ptr_b_q, ptr_q,
                          deep_b_q, deep_a_q, 2'(dm_q), 2'(im_q)};
      default:  rd_val = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Gas discharge timing
  // ----------------------------------------------------------------
  logic [8:0] hc_q;
  logic       gclk_q;
  logic [7:0] gidx_q;
  logic [2:0] gpos_q;
  logic [4:0] gchar_q;
  logic [7:0] flen;
  logic [2:0] clen;

  assign flen = (dm_q == DM_GD20) ? FRAME_LONG : FRAME_SHORT;
  assign clen = (dm_q == DM_GD18) ? CHAR_LEN6 : CHAR_LEN7;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hc_q    <= 9'h000;
      gclk_q  <= 1'b0;
      gidx_q  <= 8'h00;
      gpos_q  <= 3'h0;
      gchar_q <= 5'h00;
    end else if (hc_q == 9'(GCLK_HALF_CYC - 1)) begin
      hc_q   <= 9'h000;
      gclk_q <= !gclk_q;
      if (!gclk_q && gidx_q >= flen - 8'h01) begin
        gidx_q  <= 8'h00;
        gpos_q  <= 3'h0;
        gchar_q <= 5'h00;
      end else if (!gclk_q) begin
        gidx_q <= gidx_q + 8'h01;
        if (gpos_q == clen - 3'h1) begin
          gpos_q  <= 3'h0;
          gchar_q <= gchar_q + 5'h01;
        end else begin
          gpos_q <= gpos_q + 3'h1;
        end
      end
    end else begin
      hc_q <= hc_q + 9'h001;
    end
  end

  // ----------------------------------------------------------------
  // Display outputs
  // ----------------------------------------------------------------
  logic [3:0] ia;
  logic [3:0] ib;
  logic [4:0] gi;
  logic       gval;
  logic [5:0] ch;

  always_comb begin
    ia   = (deep_a_q ? {1'b0, s_q} : {bank_q, s_q}) + off_a_q;
    ib   = (deep_b_q ? {1'b0, s_q} : {bank_q, s_q}) + off_b_q;
    gi   = wrap_add(gchar_q, goff_q, nch);
    gval = (gpos_q < DATA_CLKS) && (gchar_q < nch) && !blank_a_q
           && !(dm_q == DM_GD18 && gidx_q >= BLANK18_IDX);
    ch   = gval ? {mem_a[gi][1:0], mem_b[gi]} : BLANK_CHAR;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disp_a_o <= 4'h0;
      disp_b_o <= 4'h0;
    end else if (gas) begin
      disp_a_o <= {gidx_q == 8'h00, gclk_q, ch[5:4]};
      disp_b_o <= ch[3:0];
    end else begin
      disp_a_o <= blank_a_q ? BLANK_IND : mem_a[ia];
      disp_b_o <= blank_b_q ? BLANK_IND : mem_b[ib];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  unselected_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_q && addr_q == REG_CMD && !sel_q && !push) |=> $stable(ptr_q) && $stable(cnt_q))
    else $error("command acted while unselected");

  fifo_bound_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (cnt_q <= FIFO_FULL) and (ovr_q |-> fstat == OVR_STATUS))
    else $error("fifo count or overrun status wrong");

  overrun_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (push && cnt_q == FIFO_FULL && !pop && !clr) |=> ovr_q && cnt_q == FIFO_FULL)
    else $error("ninth key did not set overrun");

  clear_all_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (clr && !push) |=> cnt_q == 4'h0 && !ovr_q && !int_o)
    else $error("clear left fifo state");

  read_dip_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (op_snib && kb && cnt_q > 4'h1 && !push) |=> !int_o ##1 int_o)
    else $error("interrupt did not dip on read");

  sensor_int_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (im_q == IM_SENSOR && sens_any && !clr) |=> int_o)
    else $error("sensor bit without interrupt");

  gas_alt_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (op_ard && gas && !ptr_b_q) |=> ptr_b_q && $stable(ptr_q))
    else $error("gas pointer did not alternate");

  frame_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    gidx_q < FRAME_LONG and ($rose(gclk_q) && $past(dm_q) != DM_GD20 |-> gidx_q < FRAME_SHORT))
    else $error("frame index out of range");

endmodule

// [verification/kdcu_key_model.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Key source on the return lines
// ----------------------------------------------------------------
module kdcu_key_model (
  input  wire logic       hclk,
  output logic      [7:0] ret_o,
  output logic            stb_o
);
  initial begin
    ret_o = 8'h00;
    stb_o = 1'b0;
  end
  // Code is held around the strobe, so the synchroniser sees it settled
  task automatic press(input logic [7:0] c);
    ret_o <= c;
    repeat (4) @(posedge hclk);
    stb_o <= 1'b1;
    repeat (4) @(posedge hclk);
    stb_o <= 1'b0;
    repeat (4) @(posedge hclk);
    // Lines take the inverted code once the key is gone; no stale code is left to trust
    ret_o <= ~c;
    @(posedge hclk);
  endtask
endmodule

// [verification/test_keyboard_display_command_unit.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Command unit bench
// ----------------------------------------------------------------
module test_keyboard_display_command_unit;
  import kdcu_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, stb, iq, rso;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, r, rn;
  logic [7:0]  ret, c, so;
  logic [4:0]  res;
  logic [3:0]  da, db;
  logic [3:0]  v[4];
  logic [7:0]  q[$];
  int          failures, comparisons, seed, i, n;

  kdcu_top u_kdcu_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ret_in(ret), .key_stb_in(stb),
    .disp_a_o(da), .disp_b_o(db), .scan_o(so), .bank_select_out_o(rso), .bank_select_out_oe(),
    .int_o(iq));
  kdcu_key_model u_kdcu_key_model (.hclk(hclk), .ret_o(ret), .stb_o(stb));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic stop_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Single word transfer; each phase waits for ready under a bound
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 99);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 99);
    rd = hrdata;
    if (n >= 99) begin
      failures++;
      stop_test;
    end
  endtask

  task automatic cmd(input logic [7:0] op, input logic [3:0] a, input logic ci);
    bus(1'b1, REG_CMD, {19'h0, ci, a, op}, r);
    bus(1'b0, REG_CMD, 32'h0, r);
    res = r[4:0];
  endtask

  initial begin
    seed = 78;
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, REG_STAT, 32'h0, r);
    chk(r, 32'h0000000D);
    cmd(OP_MODE, 4'h0, 1'b0);
    bus(1'b0, REG_STAT, 32'h0, r);
    chk(r, 32'h0000000D);
    bus(1'b1, REG_SEL, 32'h40, r);
    bus(1'b0, REG_SEL, 32'h0, r);
    chk(r[0], 1);
    $display("reset and select done");
    cmd(OP_PRST, 4'h0, 1'b0);
    for (i = 0; i < 4; i++) begin
      rn = $random(seed);
      // A half holds only the two top character bits
      v[i] = i[0] ? rn[3:0] : {2'h0, rn[1:0]};
      cmd(OP_AWR, v[i], 1'b0);
    end
    bus(1'b0, REG_STAT, 32'h0, r);
    chk(r[11:6], 2);
    bus(1'b1, REG_SEL, 32'h40, r);
    for (i = 0; i < 4; i++) begin
      cmd(OP_ARD, 4'h0, 1'b0);
      chk(res[3:0], v[i]);
    end
    bus(1'b1, REG_SEL, 32'h40, r);
    cmd(OP_ADD, 4'h9, 1'b1);
    chk(res, 5'h9 + v[0] + 5'h1);
    cmd(OP_SUB, 4'h9, 1'b0);
    chk(res, 5'h9 + {1'b0, ~v[0]} + 5'h1);
    cmd(OP_HWR, 4'h2, 1'b0);
    cmd(OP_HRD, 4'h0, 1'b0);
    chk(res[3:0], 4'h2);
    bus(1'b0, REG_STAT, 32'h0, r);
    chk(r[11:6], 0);
    $display("display test done");
    for (i = 0; i < 9; i++) begin
      rn = $random(seed);
      q.push_back(rn[7:0]);
      u_kdcu_key_model.press(rn[7:0]);
    end
    repeat (8) @(posedge hclk);
    cmd(OP_CNT, 4'h0, 1'b0);
    chk(res[3:0], 4'hF);
    chk(iq, 1);
    for (i = 0; i < 8; i++) begin
      c = q.pop_front();
      cmd(OP_FNIB, 4'h0, 1'b0);
      chk(res[3:0], c[7:4]);
      cmd(OP_SNIB, 4'h0, 1'b0);
      chk(res[3:0], c[3:0]);
    end
    chk(iq, 1);
    cmd(OP_FCLR, 4'h0, 1'b0);
    cmd(OP_CNT, 4'h0, 1'b0);
    chk(res[3:0], 4'h0);
    chk(iq, 0);
    $display("keyboard test done");
    // Sensor rows all see the lines left by the last key
    cmd(OP_MODE, 4'hC, 1'b0);
    cmd(OP_PRST, 4'h0, 1'b0);
    bus(1'b1, REG_SEL, 32'h40, r);
    repeat (8 * SCAN_STEP_CYC + 8) @(posedge hclk);
    c = ~q[0];
    chk(iq, c != 8'h00);
    cmd(OP_FNIB, 4'h0, 1'b0);
    chk(res[3:0], c[7:4]);
    cmd(OP_SNIB, 4'h0, 1'b0);
    chk(res[3:0], c[3:0]);
    for (n = 0; n < 2000 && da[2] !== 1'b1; n++) @(posedge hclk);
    for (n = 0; n < 2000 && da[2] !== 1'b0; n++) @(posedge hclk);
    for (n = 0; n < 2000 && da[2] !== 1'b1; n++) @(posedge hclk);
    chk(n, GCLK_HALF_CYC);
    c = so;
    for (n = 0; n < 4000 && so === c; n++) @(posedge hclk);
    c = so;
    for (n = 0; n < 4000 && so === c; n++) @(posedge hclk);
    chk(n, SCAN_STEP_CYC);
    chk(so, {c[6:0], c[7]});
    chk(rso, 0);
    bus(1'b1, REG_SEL, 32'h60, r);
    repeat (2) @(posedge hclk);
    chk({da[1:0], db}, BLANK_CHAR);
    $display("sensor and output test done");
    stop_test;
  end
endmodule
